// ===== inc/sagc_pkg.sv
// Package of register map, field layout and reset values for the config slice
package sagc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          TH_W            = 16;
  localparam int          PERS_W          = 4;
  // Register offsets
  localparam logic [7:0]  ADDR_LOW_LIM_B0 = 8'h84;
  localparam logic [7:0]  ADDR_LOW_LIM_B1 = 8'h85;
  localparam logic [7:0]  ADDR_HI_LIM_B0  = 8'h86;
  localparam logic [7:0]  ADDR_HI_LIM_B1  = 8'h87;
  localparam logic [7:0]  ADDR_AUX_ID     = 8'h90;
  localparam logic [7:0]  ADDR_REVISION_CODE     = 8'h91;
  localparam logic [7:0]  ADDR_PART_ID    = 8'h92;
  localparam logic [7:0]  ADDR_FIFO_AGC   = 8'hb1;
  localparam logic [7:0]  ADDR_GAIN_CEIL  = 8'hcf;
  // Field positions
  localparam int          FLK_CEIL_LSB    = 4;
  localparam int          SPC_CEIL_LSB    = 0;
  localparam int          FIFO_SEL_LSB    = 6;
  localparam int          FLK_AGC_BIT     = 3;
  localparam int          SPC_AGC_BIT     = 2;
  localparam int          PART_ID_LSB     = 2;
  // Reset values and limits
  localparam logic [3:0]  CEIL_RST        = 4'h9;
  localparam logic [3:0]  CEIL_MAX        = 4'ha;
  localparam logic [1:0]  FIFO_SEL_RST    = 2'h2;
  localparam logic        FLK_AGC_RST     = 1'b1;
  localparam logic        SPC_AGC_RST     = 1'b0;
  localparam logic [7:0]  LIM_BYTE_RST    = 8'h00;
  // Identification codes, arbitrary values
  localparam logic [3:0]  AUX_CODE        = 4'h5;
  localparam logic [2:0]  REV_CODE        = 3'h3;
  localparam logic [5:0]  PART_CODE       = 6'h2a;
  // FIFO level encodings
  localparam logic [4:0]  FIFO_LVL_0      = 5'h01;
  localparam logic [4:0]  FIFO_LVL_1      = 5'h04;
  localparam logic [4:0]  FIFO_LVL_2      = 5'h08;
  localparam logic [4:0]  FIFO_LVL_3      = 5'h10;
endpackage

// ===== design/sagc_limit_pair.sv
// One 16-bit threshold with low byte holding latch and atomic update
`timescale 1ns/1ps
module sagc_limit_pair
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  hold_r,
  output logic      [15:0] active_r
);
  logic [7:0]  hold_nxt;
  logic [15:0] active_nxt;

  always_comb
  begin
    hold_nxt   = hold_r;
    active_nxt = active_r;
    if (wr_lo)
    begin
      hold_nxt = wdata;                 // see [R10]
    end
    if (wr_hi)
    begin
      active_nxt = {wdata, hold_r};     // see [R11]
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_r   <= sagc_pkg::LIM_BYTE_RST;
      active_r <= {sagc_pkg::LIM_BYTE_RST, sagc_pkg::LIM_BYTE_RST}; // see [R9]
    end
    else
    begin
      hold_r   <= hold_nxt;
      active_r <= active_nxt;
    end
  end
endmodule

// ===== design/sagc_config_regs.sv
// Gain ceiling, FIFO level, AGC enable, identification and threshold registers
//
// Functional notes
// [R1] Upper nibble of gain ceiling caps flicker gain at 2^n, reset 9, range 0-10.
// [R2] Lower nibble caps spectral gain at 2^n, reset 9, range 0-10.
// [R3] Two-bit FIFO select picks level 1/4/8/16, reset 2.
// [R4] Flicker AGC enable bit, reset one.
// [R5] Spectral AGC enable bit, reset zero.
// [R6] Auxiliary, revision and part codes are read only.
// [R7] Low and high 16-bit thresholds compared to channel zero each measurement.
// [R8] Result outside window for persistence count with enable sets interrupt.
// [R9] Threshold bytes at 0x84, 0x85, 0x86, 0x87 reset zero, pairs form 16 bits.
// [R10] Low byte write goes to an 8-bit holding latch.
// [R11] High byte write updates both active bytes at once.
// [R12] Host must follow a low byte write with the high byte.
// [R13] Host should write both bytes in one bus transaction; wr_pair in the host model issues two separate byte writes.
// [R14] Result above high threshold with persistence reached raises interrupt.
// [R15] Host keeps ceiling fields at ten or below; device clamps.
`timescale 1ns/1ps
module sagc_config_regs
#(
  parameter int PERS_W = sagc_pkg::PERS_W
)
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              meas_done,
  input  wire logic [15:0]       channel_zero_result,
  input  wire logic              spectral_irq_enable,
  input  wire logic [PERS_W-1:0] spectral_persistence_count,
  input  wire logic              irq_clear,
  output logic                   spectral_irq,
  output logic      [3:0]        flicker_gain_ceiling,
  output logic      [3:0]        spectral_gain_ceiling,
  output logic      [4:0]        fifo_irq_level,
  output logic                   flicker_autogain_enable,
  output logic                   spectral_autogain_enable,
  output logic      [15:0]       low_limit,
  output logic      [15:0]       high_limit
);
  initial
  begin
    if (PERS_W < 1 || PERS_W > 8)
      $error("PERS_W out of range");
  end

  // ****************************************************
  // Register writes
  // ****************************************************
  logic [3:0]        flk_ceil_r, flk_ceil_nxt;
  logic [3:0]        spc_ceil_r, spc_ceil_nxt;
  logic [1:0]        fifo_sel_r, fifo_sel_nxt;
  logic              flk_agc_r,  flk_agc_nxt;
  logic              spc_agc_r,  spc_agc_nxt;
  logic [4:0]        fifo_lvl_r, fifo_lvl_nxt;
  logic [7:0]        rdata_r,    rdata_nxt;
  logic [7:0]        lo_hold;
  logic [7:0]        hi_hold;
  logic [15:0]       lo_act;
  logic [15:0]       hi_act;
  logic [PERS_W-1:0] pers_r,     pers_nxt;
  logic              irq_r,      irq_nxt;

  function automatic logic [3:0] clamp_ceil(input logic [3:0] v);
    clamp_ceil = (v > sagc_pkg::CEIL_MAX) ? sagc_pkg::CEIL_MAX : v;
  endfunction

  sagc_limit_pair u_low
  (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wr_lo    (reg_wr && reg_addr == sagc_pkg::ADDR_LOW_LIM_B0), // see [R9]
    .wr_hi    (reg_wr && reg_addr == sagc_pkg::ADDR_LOW_LIM_B1), // see [R9]
    .wdata    (reg_wdata),
    .hold_r   (lo_hold),
    .active_r (lo_act)
  );

  sagc_limit_pair u_high
  (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wr_lo    (reg_wr && reg_addr == sagc_pkg::ADDR_HI_LIM_B0),  // see [R9]
    .wr_hi    (reg_wr && reg_addr == sagc_pkg::ADDR_HI_LIM_B1),
    .wdata    (reg_wdata),
    .hold_r   (hi_hold),
    .active_r (hi_act)
  );

  always_comb
  begin
    flk_ceil_nxt = flk_ceil_r;
    spc_ceil_nxt = spc_ceil_r;
    fifo_sel_nxt = fifo_sel_r;
    flk_agc_nxt  = flk_agc_r;
    spc_agc_nxt  = spc_agc_r;
    if (reg_wr)
    begin
      unique case (reg_addr)
        sagc_pkg::ADDR_GAIN_CEIL:
        begin
          flk_ceil_nxt = clamp_ceil(reg_wdata[7:4]);   // see [R1] see [R15]
          spc_ceil_nxt = clamp_ceil(reg_wdata[3:0]);   // see [R2]
        end
        sagc_pkg::ADDR_FIFO_AGC:
        begin
          fifo_sel_nxt = reg_wdata[7:6];               // see [R3]
          flk_agc_nxt  = reg_wdata[sagc_pkg::FLK_AGC_BIT]; // see [R4]
          spc_agc_nxt  = reg_wdata[sagc_pkg::SPC_AGC_BIT]; // see [R5]
        end
        default:
        begin
          // Identification and unmapped writes ignored, see [R6]
        end
      endcase
    end
    unique case (fifo_sel_nxt)                         // see [R3]
      2'h0:    fifo_lvl_nxt = sagc_pkg::FIFO_LVL_0;
      2'h1:    fifo_lvl_nxt = sagc_pkg::FIFO_LVL_1;
      2'h2:    fifo_lvl_nxt = sagc_pkg::FIFO_LVL_2;
      2'h3:    fifo_lvl_nxt = sagc_pkg::FIFO_LVL_3;
    endcase
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      unique case (reg_addr)
        sagc_pkg::ADDR_LOW_LIM_B0: rdata_nxt = lo_act[7:0];
        sagc_pkg::ADDR_LOW_LIM_B1: rdata_nxt = lo_act[15:8];
        sagc_pkg::ADDR_HI_LIM_B0:  rdata_nxt = hi_act[7:0];
        sagc_pkg::ADDR_HI_LIM_B1:  rdata_nxt = hi_act[15:8];
        sagc_pkg::ADDR_AUX_ID:     rdata_nxt = {4'h0, sagc_pkg::AUX_CODE};
        sagc_pkg::ADDR_REVISION_CODE:     rdata_nxt = {5'h00, sagc_pkg::REV_CODE};
        sagc_pkg::ADDR_PART_ID:    rdata_nxt = {sagc_pkg::PART_CODE, 2'h0};
        sagc_pkg::ADDR_FIFO_AGC:   rdata_nxt = {fifo_sel_r, 2'h0, flk_agc_r,
                                               spc_agc_r, 2'h0};
        sagc_pkg::ADDR_GAIN_CEIL:  rdata_nxt = {flk_ceil_r, spc_ceil_r};
        default:                   rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************************
  // Threshold compare and persistence
  // ****************************************************
  always_comb
  begin
    logic outside;
    outside  = 1'b0;
    pers_nxt = pers_r;
    irq_nxt  = irq_r;
    if (meas_done)
    begin
      outside = (channel_zero_result < lo_act) ||      // see [R7]
                (channel_zero_result > hi_act);        // see [R14]
      if (!outside)
        pers_nxt = '0;
      else if (pers_r != {PERS_W{1'b1}})
        pers_nxt = pers_r + 1'b1;
      if (outside && spectral_irq_enable &&
          (pers_nxt >= spectral_persistence_count))
        irq_nxt = 1'b1;                                // see [R8] see [R14]
    end
    if (irq_clear && !irq_nxt)
      irq_nxt = 1'b0;
    else if (irq_clear && irq_r && !(meas_done && outside &&
             spectral_irq_enable &&
             pers_nxt >= spectral_persistence_count))
      irq_nxt = 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flk_ceil_r <= sagc_pkg::CEIL_RST;     // see [R1]
      spc_ceil_r <= sagc_pkg::CEIL_RST;     // see [R2]
      fifo_sel_r <= sagc_pkg::FIFO_SEL_RST; // see [R3]
      flk_agc_r  <= sagc_pkg::FLK_AGC_RST;  // see [R4]
      spc_agc_r  <= sagc_pkg::SPC_AGC_RST;  // see [R5]
      fifo_lvl_r <= sagc_pkg::FIFO_LVL_2;
      rdata_r    <= 8'h00;
      pers_r     <= '0;
      irq_r      <= 1'b0;
    end
    else
    begin
      flk_ceil_r <= flk_ceil_nxt;
      spc_ceil_r <= spc_ceil_nxt;
      fifo_sel_r <= fifo_sel_nxt;
      flk_agc_r  <= flk_agc_nxt;
      spc_agc_r  <= spc_agc_nxt;
      fifo_lvl_r <= fifo_lvl_nxt;
      rdata_r    <= rdata_nxt;
      pers_r     <= pers_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign reg_rdata                = rdata_r;
  assign spectral_irq             = irq_r;
  assign flicker_gain_ceiling     = flk_ceil_r;
  assign spectral_gain_ceiling    = spc_ceil_r;
  assign fifo_irq_level           = fifo_lvl_r;
  assign flicker_autogain_enable  = flk_agc_r;
  assign spectral_autogain_enable = spc_agc_r;
  assign low_limit                = lo_act;
  assign high_limit               = hi_act;
endmodule

// ===== tb/sagc_config_regs_assertions.sv
// Port checker for the config slice
`timescale 1ns/1ps
module sagc_config_regs_assertions
#(
  parameter int PERS_W = 4
)
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic              meas_done,
  input wire logic [15:0]       channel_zero_result,
  input wire logic              spectral_irq_enable,
  input wire logic [PERS_W-1:0] spectral_persistence_count,
  input wire logic              spectral_irq,
  input wire logic [3:0]        flicker_gain_ceiling,
  input wire logic [3:0]        spectral_gain_ceiling,
  input wire logic [4:0]        fifo_irq_level,
  input wire logic              flicker_autogain_enable,
  input wire logic              spectral_autogain_enable,
  input wire logic [15:0]       low_limit,
  input wire logic [15:0]       high_limit
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_CEIL_MAX: assert property (
    flicker_gain_ceiling <= 4'ha && spectral_gain_ceiling <= 4'ha)
    else $error("gain ceiling above ten");
  AST_CFG_HOLD: assert property (
    !(reg_wr && reg_addr inside {8'hcf, 8'hb1}) |=> $stable({
    flicker_gain_ceiling, spectral_gain_ceiling, fifo_irq_level,
    flicker_autogain_enable, spectral_autogain_enable}))
    else $error("config changed without write");
  AST_FIFO_LVL: assert property (
    fifo_irq_level inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("fifo level not decoded");
  AST_LOW_HOLD: assert property (
    !(reg_wr && reg_addr == 8'h85) |=> $stable(low_limit))
    else $error("low limit moved without high byte");
  AST_LOW_LOAD: assert property (
    reg_wr && reg_addr == 8'h85 |=> low_limit[15:8] == $past(reg_wdata))
    else $error("low limit high byte not loaded");
  AST_IRQ_SET: assert property (
    meas_done && spectral_irq_enable && spectral_persistence_count <= 1
    && channel_zero_result > high_limit |=> spectral_irq)
    else $error("interrupt not raised");
  AST_IRQ_QUIET: assert property (
    !spectral_irq && !(meas_done && spectral_irq_enable) |=> !spectral_irq)
    else $error("interrupt without enabled result");
  AST_ID_RO: assert property (
    reg_rd && reg_addr == 8'h92 |=> reg_rdata[7:2] == sagc_pkg::PART_CODE)
    else $error("part code wrong");
endmodule
bind sagc_config_regs sagc_config_regs_assertions #(.PERS_W(PERS_W)) u_chk (.*);

// ===== tb/sagc_host_model.sv
// Host model driving the register bus
`timescale 1ns/1ps
module sagc_host_model
(
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Low byte then high byte at the next address, one idle cycle between
  task automatic wr_pair(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// ===== tb/sagc_config_regs_tb_top.sv
// Self-checking bench of the config slice
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, e, a); end end
module sagc_config_regs_tb_top;
  logic        mclk, sys_rst, reg_wr, reg_rd, meas_done, irq_en;
  logic        irq_clear, spectral_irq, fen, sen;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [15:0] res, low_limit, high_limit;
  logic [3:0]  pers, flk, spc;
  logic [4:0]  lvl;
  int          miscompares = 0;
  int          n_compared = 0;
  sagc_host_model u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  sagc_config_regs #(.PERS_W(4)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_done(meas_done),
    .channel_zero_result(res), .spectral_irq_enable(irq_en),
    .spectral_persistence_count(pers), .irq_clear(irq_clear),
    .spectral_irq(spectral_irq), .flicker_gain_ceiling(flk),
    .spectral_gain_ceiling(spc), .fifo_irq_level(lvl),
    .flicker_autogain_enable(fen), .spectral_autogain_enable(sen),
    .low_limit(low_limit), .high_limit(high_limit));
  always #2.5 mclk = ~mclk;
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rd_v);
    `CHK("rdata", e, rd_v)
  endtask
  task automatic meas(input logic [15:0] r);
    @(negedge mclk);
    meas_done = 1'b1;
    res = r;
    @(negedge mclk);
    meas_done = 1'b0;
    res = ~r;
  endtask
  task automatic clr();
    @(negedge mclk);
    irq_clear = 1'b1;
    @(negedge mclk);
    irq_clear = 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0; sys_rst = 1'b1; meas_done = 1'b0; irq_en = 1'b0;
    irq_clear = 1'b0; res = 16'h0000; pers = 4'h1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    `CHK("flk", 4'h9, flk)
    `CHK("spc", 4'h9, spc)
    `CHK("lvl", 5'h08, lvl)
    `CHK("fen", 1'b1, fen)
    `CHK("sen", 1'b0, sen)
    `CHK("lims", 32'h0, {low_limit, high_limit})
    rdchk(8'hcf, 8'h99);
    rdchk(8'h90, {4'h0, sagc_pkg::AUX_CODE});
    rdchk(8'h91, {5'h00, sagc_pkg::REV_CODE});
    u_host.wr(8'h92, 8'h00);
    rdchk(8'h92, {sagc_pkg::PART_CODE, 2'b00});
    rdchk(8'h20, 8'h00);
    $display("test reset_and_ids done");
    u_host.wr(8'hcf, 8'hfb);
    `CHK("clamp", 8'haa, {flk, spc})
    u_host.wr(8'hcf, 8'ha3);
    `CHK("ceil", 8'ha3, {flk, spc})
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(8'hb1, {i[1:0], 2'b00, i[0], i[1], 2'b00});
      `CHK("lvl", 5'h01 << (i == 0 ? 0 : i + 1), lvl)
      `CHK("agc", {i[0], i[1]}, {fen, sen})
    end
    $display("test config done");
    u_host.wr(8'h84, 8'haa);
    `CHK("low", 16'h0000, low_limit)
    rdchk(8'h84, 8'h00);
    u_host.wr(8'h85, 8'hbb);
    `CHK("low", 16'hbbaa, low_limit)
    u_host.wr_pair(8'h84, 16'h0100);
    u_host.wr_pair(8'h86, 16'h1000);
    `CHK("lims", 32'h01001000, {low_limit, high_limit})
    $display("test thresholds done");
    irq_en = 1'b1;
    meas(16'h0800);
    `CHK("irq", 1'b0, spectral_irq)
    meas(16'h2000);
    `CHK("irq", 1'b1, spectral_irq)
    clr();
    meas(16'h0050);
    `CHK("irq", 1'b1, spectral_irq)
    clr();
    irq_en = 1'b0;
    meas(16'h2000);
    `CHK("irq", 1'b0, spectral_irq)
    irq_en = 1'b1;
    pers = 4'h3;
    meas(16'h0800);
    meas(16'h2000);
    meas(16'h2000);
    `CHK("irq", 1'b0, spectral_irq)
    meas(16'h2000);
    `CHK("irq", 1'b1, spectral_irq)
    $display("test interrupt done");
    give_verdict();
  end
endmodule
